// ===== ssw_bank.sv
// Secondary status and memory window register bank of one bridge port.
// Assumes an AXI4-Lite master, synchronous event inputs and one clock.
// What this block does
// - Status bit 21 reads one, read-only, reporting 66 MHz capability.
// - Status bit 23 reads zero, read-only, fast back-to-back capability.
// - Bit 24 sets on either parity error line while command bit 6 set.
// - Bits 26:25 read-only, return medium timing code 01.
// - Bit 27 sets when bridge as target signals target abort.
// - Bit 28 sets when bridge-mastered transaction receives target abort.
// - Bit 29 sets when bridge-mastered transaction ends in master abort.
// - Bit 30 sets when either secondary system error line is asserted.
// - Bit 31 sets on address or data parity error detected.
// - Memory base bits 3:0 read-only zero.
// - Memory base bits 15:4 writable, reset zero, give window bottom 31:20.
// - Memory limit bits 19:16 read-only zero.
// - Memory limit bits 31:20 writable, window top low bits all ones.
// - Base and limit decide whether a memory address is forwarded.
// - Prefetch base 15:4 writable; bits 3:0 read 0001 for 64-bit.
`timescale 1ns/100ps
module ssw_bank import ssw_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire ssw_events_t events,
  input  wire logic [31:0] memAddr,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             commandParityResponse,
  output logic             memForward,
  output logic             irq
);

  ssw_state_t st;
  ssw_state_t next_st;

  // Read mux, shared by the read and write paths; decode is by word address.
  function automatic logic [31:0] readWord(input ssw_state_t s, input logic [7:0] a, output logic hit);
    logic [31:0] v;
    v   = 32'h00000000;
    hit = 1'b1;
    unique case (a)
      SSW_OFF_STATUS: begin
        v[31:SSW_FLAG_LO]          = s.flags & SSW_FLAG_MASK;
        v[SSW_B_66MHZ]             = 1'b1;
        v[SSW_B_FB2B]              = 1'b0;
        v[SSW_B_DEVLO+1:SSW_B_DEVLO] = SSW_DEVSEL_MEDIUM;
      end
      SSW_OFF_MEMWIN:   v = {s.memLimit, 4'h0, s.memBase, 4'h0};
      SSW_OFF_PREFBASE: v = {16'h0000, s.prefBase, SSW_ADDR64_CODE};
      SSW_OFF_CTRL:     v = s.ctrl;
      SSW_OFF_IRQMASK:  v = {24'h000000, s.irqMask};
      default:          hit = 1'b0;
    endcase
    return v;
  endfunction : readWord

  // Byte-lane merge used by every writable word.
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return v;
  endfunction : laneMerge

  // Next state: events, bus write, bus read, window compare and interrupt.
  always_comb begin
    logic [7:0]  setBits;
    logic [7:0]  clrBits;
    logic [7:0]  readClr;
    logic [31:0] w;
    logic [31:0] rd;
    logic        hit;
    logic        doWrite;
    next_st = st;
    setBits = 8'h00;
    clrBits = 8'h00;
    readClr = 8'h00;
    w       = 32'h00000000;
    rd      = 32'h00000000;
    hit     = 1'b0;
    // Event sources, mapped to status bits 31..24.
    setBits[SSW_B_DPE - SSW_FLAG_LO]   = (~events.parity1N | ~events.parity2N) & st.ctrl[SSW_CTRL_PERRESP];
    setBits[SSW_B_STA - SSW_FLAG_LO]   = events.targetAbortSent;
    setBits[SSW_B_RTA - SSW_FLAG_LO]   = events.targetAbortRecv;
    setBits[SSW_B_RMA - SSW_FLAG_LO]   = events.masterAbortRecv;
    setBits[SSW_B_RSE - SSW_FLAG_LO]   = ~events.system1N | ~events.system2N;
    setBits[SSW_B_DPERR - SSW_FLAG_LO] = events.parityDetected;

    // Write channels are accepted independently and held until both arrive.
    if (s_axi_awvalid && !st.awDone && !st.bValid) begin
      next_st.awDone = 1'b1;
      next_st.awAddr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !st.wDone && !st.bValid) begin
      next_st.wDone = 1'b1;
      next_st.wData = s_axi_wdata;
    end
    doWrite = st.awDone && st.wDone && !st.bValid;
    if (doWrite) begin
      next_st.awDone = 1'b0;
      next_st.wDone  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = 2'b00;
      w = laneMerge(readWord(st, st.awAddr, hit), st.wData, 4'hF);
      unique case (st.awAddr)
        SSW_OFF_STATUS:   clrBits = st.wData[31:SSW_FLAG_LO] & SSW_FLAG_MASK;
        SSW_OFF_MEMWIN: begin
          w = laneMerge({st.memLimit, 4'h0, st.memBase, 4'h0}, st.wData, 4'hF);
          next_st.memBase  = w[15:4];
          next_st.memLimit = w[31:20];
        end
        SSW_OFF_PREFBASE: next_st.prefBase = w[15:4];
        SSW_OFF_CTRL:     next_st.ctrl     = w;
        SSW_OFF_IRQMASK:  next_st.irqMask  = w[7:0] & SSW_FLAG_MASK;
        default:          next_st.bResp    = 2'b10;
      endcase
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end

    // Single outstanding read; a status read clears the sticky bits it returned.
    next_st.arReady = !st.rValid && !st.arReady;
    if (s_axi_arvalid && st.arReady) begin
      rd = readWord(st, {s_axi_araddr[7:2], 2'b00}, hit);
      next_st.arReady = 1'b0;
      next_st.rValid  = 1'b1;
      next_st.rData   = rd;
      next_st.rResp   = hit ? 2'b00 : 2'b10;
      if (s_axi_araddr[7:2] == SSW_OFF_STATUS[7:2]) begin
        readClr = st.flags;
      end
    end
    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end

    // Set wins over any clear arriving in the same cycle.
    next_st.flags = ((st.flags & ~clrBits & ~readClr) | setBits) & SSW_FLAG_MASK;
    next_st.irq   = |(next_st.flags & next_st.irqMask);
    // Window hit: bottom has low 20 bits zero, top has low 20 bits ones.
    next_st.fwd   = (memAddr[31:20] >= st.memBase) && (memAddr[31:20] <= st.memLimit);
  end

  // State register; every field has a constant reset value.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st          <= '0;
      st.memBase  <= SSW_WIN_RESET;
      st.memLimit <= SSW_WIN_RESET;
      st.prefBase <= SSW_WIN_RESET;
      st.ctrl     <= SSW_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come from state flip-flops; awready and wready are gated from awDone, wDone and bValid.
  assign s_axi_awready         = !st.awDone && !st.bValid;
  assign s_axi_wready          = !st.wDone && !st.bValid;
  assign s_axi_bvalid          = st.bValid;
  assign s_axi_bresp           = st.bResp;
  assign s_axi_arready         = st.arReady;
  assign s_axi_rvalid          = st.rValid;
  assign s_axi_rdata           = st.rData;
  assign s_axi_rresp           = st.rResp;
  assign commandParityResponse = st.ctrl[SSW_CTRL_PERRESP];
  assign memForward            = st.fwd;
  assign irq                   = st.irq;

  // Checks kept next to the logic they guard.
  a_abort_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
    events.targetAbortSent |=> st.flags[SSW_B_STA - SSW_FLAG_LO])
    else $error("Target abort event did not set its status bit.");
  a_mabort_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
    events.masterAbortRecv |=> st.flags[SSW_B_RMA - SSW_FLAG_LO])
    else $error("Master abort event did not set its status bit.");
  a_rtabort_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
    events.targetAbortRecv |=> st.flags[SSW_B_RTA - SSW_FLAG_LO])
    else $error("Received target abort did not set its status bit.");
  a_serr_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
    (!events.system1N || !events.system2N) |=> st.flags[SSW_B_RSE - SSW_FLAG_LO])
    else $error("System error did not set its status bit.");
  a_perr_gated_flag: assert property (@(posedge clk) disable iff (!rstn)
    (!st.flags[0] && !st.ctrl[SSW_CTRL_PERRESP] && !(s_axi_awvalid && s_axi_wvalid)) |=> !st.flags[0])
    else $error("Parity flag set while parity response disabled.");
  a_dperr_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
    events.parityDetected |=> st.flags[SSW_B_DPERR - SSW_FLAG_LO])
    else $error("Detected parity error did not set its status bit.");
  a_fixed_status: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(s_axi_rvalid) && $past(s_axi_araddr) == SSW_OFF_STATUS)
      |-> ({s_axi_rdata[26:25], s_axi_rdata[23:21]} == 5'b01001))
    else $error("Fixed status fields read back wrong.");
  a_window_decode: assert property (@(posedge clk) disable iff (!rstn)
    (memAddr[31:20] < st.memBase) |=> !memForward)
    else $error("Address below window was forwarded.");
  a_zero_keeps: assert property (@(posedge clk) disable iff (!rstn)
    (st.flags[7] && !(s_axi_arvalid && st.arReady) && st.awDone && st.wDone && !st.bValid && !st.wData[31])
      |=> st.flags[7])
    else $error("Writing zero cleared a sticky status bit.");

  // Response channels must hold their answer until the master takes it.
  a_bvalid_holds: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("Write response dropped before it was taken.");

  a_bresp_stable: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_bvalid && !s_axi_bready) |=> $stable(s_axi_bresp))
    else $error("Write response code changed while pending.");

  a_rvalid_holds: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid)
    else $error("Read data dropped before it was taken.");

  a_rdata_stable: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_rvalid && !s_axi_rready) |=> $stable(s_axi_rdata))
    else $error("Read data changed while pending.");

  a_rresp_stable: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_rvalid && !s_axi_rready) |=> $stable(s_axi_rresp))
    else $error("Read response code changed while pending.");

  // A pending answer blocks new requests, so one of each is under way at most.
  a_aw_busy: assert property (@(posedge clk) disable iff (!rstn)
    s_axi_bvalid |-> !s_axi_awready)
    else $error("Write address accepted while a response was pending.");

  a_w_busy: assert property (@(posedge clk) disable iff (!rstn)
    s_axi_bvalid |-> !s_axi_wready)
    else $error("Write data accepted while a response was pending.");

  a_ar_busy: assert property (@(posedge clk) disable iff (!rstn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address accepted while read data was pending.");

  a_bresp_legal: assert property (@(posedge clk) disable iff (!rstn)
    s_axi_bvalid |-> (s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10))
    else $error("Write response code out of range.");

  a_rresp_legal: assert property (@(posedge clk) disable iff (!rstn)
    s_axi_rvalid |-> (s_axi_rresp == 2'b00 || s_axi_rresp == 2'b10))
    else $error("Read response code out of range.");

  a_write_answer: assert property (@(posedge clk) disable iff (!rstn)
    (st.awDone && st.wDone && !st.bValid) |=> s_axi_bvalid)
    else $error("Write response did not follow a complete write.");

  a_read_answer: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("Read data did not follow an accepted address.");

  a_bvalid_drops: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("Write response repeated after it was taken.");

  a_rvalid_drops: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("Read data repeated after it was taken.");

  // Read-only fields seen on the bus; the address is taken one cycle before data.
  a_status_bits: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(s_axi_rvalid) && $past(s_axi_araddr) == SSW_OFF_STATUS) |-> (s_axi_rdata[22:16] == 7'h20))
    else $error("Status capability bits read back wrong.");

  a_status_low: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(s_axi_rvalid) && $past(s_axi_araddr) == SSW_OFF_STATUS) |-> (s_axi_rdata[15:0] == 16'h0000))
    else $error("Lower half of the status word is not zero.");

  a_memwin_ro: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(s_axi_rvalid) && $past(s_axi_araddr) == SSW_OFF_MEMWIN)
      |-> (s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[19:16] == 4'h0))
    else $error("Read-only window bits are not zero.");

  a_pref_code: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(s_axi_rvalid) && $past(s_axi_araddr) == SSW_OFF_PREFBASE) |-> (s_axi_rdata[3:0] == SSW_ADDR64_CODE))
    else $error("Prefetch base does not report 64-bit addressing.");

  a_pref_upper: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(s_axi_rvalid) && $past(s_axi_araddr) == SSW_OFF_PREFBASE) |-> (s_axi_rdata[31:16] == 16'h0000))
    else $error("Upper half of the prefetch word is not zero.");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_rvalid && s_axi_rresp == 2'b10) |-> (s_axi_rdata == 32'h00000000))
    else $error("Refused read returned data.");

  // Writes land in the window fields; the write data stays held for a cycle.
  a_base_write: assert property (@(posedge clk) disable iff (!rstn)
    (st.awDone && st.wDone && !st.bValid && st.awAddr == SSW_OFF_MEMWIN) |=> (st.memBase == st.wData[15:4]))
    else $error("Memory base write did not land.");

  a_limit_write: assert property (@(posedge clk) disable iff (!rstn)
    (st.awDone && st.wDone && !st.bValid && st.awAddr == SSW_OFF_MEMWIN) |=> (st.memLimit == st.wData[31:20]))
    else $error("Memory limit write did not land.");

  a_pref_write: assert property (@(posedge clk) disable iff (!rstn)
    (st.awDone && st.wDone && !st.bValid && st.awAddr == SSW_OFF_PREFBASE) |=> (st.prefBase == st.wData[15:4]))
    else $error("Prefetch base write did not land.");

  // Write-one and read clears, unless a new event sets the bit again.
  a_w1c_dperr: assert property (@(posedge clk) disable iff (!rstn)
    (st.awDone && st.wDone && !st.bValid && st.awAddr == SSW_OFF_STATUS && st.wData[31] && !events.parityDetected)
      |=> !st.flags[7])
    else $error("Writing one did not clear the parity status bit.");

  a_w1c_rtabort: assert property (@(posedge clk) disable iff (!rstn)
    (st.awDone && st.wDone && !st.bValid && st.awAddr == SSW_OFF_STATUS && st.wData[28] && !events.targetAbortRecv)
      |=> !st.flags[4])
    else $error("Writing one did not clear the received abort bit.");

  a_read_clears: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == SSW_OFF_STATUS && !events.parityDetected) |=> !st.flags[7])
    else $error("Status read did not clear the parity status bit.");

  // Flags, interrupt and window decode.
  a_flag_gaps: assert property (@(posedge clk) disable iff (!rstn)
    (st.flags & ~SSW_FLAG_MASK) == 8'h00)
    else $error("Timing code positions held a sticky bit.");

  a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    irq == (|(st.flags & st.irqMask)))
    else $error("Interrupt level disagrees with masked status.");

  a_fwd_inside: assert property (@(posedge clk) disable iff (!rstn)
    (memAddr[31:20] >= st.memBase && memAddr[31:20] <= st.memLimit) |=> memForward)
    else $error("Address inside the window was not forwarded.");

  a_fwd_above: assert property (@(posedge clk) disable iff (!rstn)
    (memAddr[31:20] > st.memLimit) |=> !memForward)
    else $error("Address above the window was forwarded.");

  a_dpe_port1: assert property (@(posedge clk) disable iff (!rstn)
    (!events.parity1N && st.ctrl[SSW_CTRL_PERRESP]) |=> st.flags[SSW_B_DPE - SSW_FLAG_LO])
    else $error("First port parity error did not set its status bit.");

  a_dpe_port2: assert property (@(posedge clk) disable iff (!rstn)
    (!events.parity2N && st.ctrl[SSW_CTRL_PERRESP]) |=> st.flags[SSW_B_DPE - SSW_FLAG_LO])
    else $error("Second port parity error did not set its status bit.");

endmodule : ssw_bank

// ===== ssw_pkg.sv
// Package for the secondary status and memory window register bank.
// Assumes a 32-bit AXI4-Lite register bus and a single clock domain.
package ssw_pkg;

  // Byte addresses of the register words.
  localparam logic [7:0] SSW_OFF_STATUS   = 8'h1C;
  localparam logic [7:0] SSW_OFF_MEMWIN   = 8'h20;
  localparam logic [7:0] SSW_OFF_PREFBASE = 8'h24;
  localparam logic [7:0] SSW_OFF_CTRL     = 8'h40;
  localparam logic [7:0] SSW_OFF_IRQMASK  = 8'h44;

  // Secondary status bit positions within the 1Ch word.
  localparam int SSW_B_66MHZ  = 21;
  localparam int SSW_B_FB2B   = 23;
  localparam int SSW_B_DPE    = 24;
  localparam int SSW_B_DEVLO  = 25;
  localparam int SSW_B_STA    = 27;
  localparam int SSW_B_RTA    = 28;
  localparam int SSW_B_RMA    = 29;
  localparam int SSW_B_RSE    = 30;
  localparam int SSW_B_DPERR  = 31;
  localparam int SSW_FLAG_LO  = 24;
  localparam int SSW_NFLAGS   = 8;

  // Fixed values of the read-only fields.
  localparam logic [1:0]  SSW_DEVSEL_MEDIUM = 2'h1;
  localparam logic [3:0]  SSW_ADDR64_CODE   = 4'h1;
  localparam logic [11:0] SSW_WIN_RESET     = 12'h000;
  // Flag mask: bits 24, 27..31 are sticky; 25 and 26 are the timing code.
  localparam logic [7:0]  SSW_FLAG_MASK     = 8'hF9;
  localparam logic [31:0] SSW_CTRL_RESET    = 32'h00000000;
  localparam int          SSW_CTRL_PERRESP  = 6;

  // Secondary bus events, one cycle pulses or levels.
  typedef struct packed {
    logic parity1N;
    logic parity2N;
    logic system1N;
    logic system2N;
    logic targetAbortSent;
    logic targetAbortRecv;
    logic masterAbortRecv;
    logic parityDetected;
  } ssw_events_t;

  // Whole state of the bank.
  typedef struct packed {
    logic [7:0]  flags;
    logic [11:0] memBase;
    logic [11:0] memLimit;
    logic [11:0] prefBase;
    logic [31:0] ctrl;
    logic [7:0]  irqMask;
    logic        awDone;
    logic        wDone;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [1:0]  rResp;
    logic [31:0] rData;
    logic        arReady;
    logic        irq;
    logic        fwd;
  } ssw_state_t;

endpackage : ssw_pkg

// ===== ssw_agents.sv
// Model of the secondary bus agents that raise error and abort events.
// Assumes the bench names one event bit and pulses go for one cycle.
`timescale 1ns/100ps
module ssw_agents import ssw_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       go,
  input  wire logic [2:0] sel,
  output ssw_events_t     events
);
  // The four error lines are active low, so they rest high.
  localparam logic [7:0] SSW_IDLE = 8'hF0;
  // One event cycle per request, so a flag that is not sticky is caught.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      events <= SSW_IDLE;
    end else begin
      events <= go ? (SSW_IDLE ^ (8'h01 << sel)) : SSW_IDLE;
    end
  end
endmodule : ssw_agents

// ===== ssw_bank_bench.sv
// Self-checking bench for the secondary status and memory window bank.
// Assumes the AXI4-Lite timing of the bank and the agent model beside it.
`timescale 1ns/100ps
module ssw_bank_bench import ssw_pkg::*;;
  logic        clk, rstn, go, awValid, wValid, bReady, arValid, rReady;
  logic        awReady, wReady, bValid, arReady, rValid, cmdPar, fwd, irq;
  logic [2:0]  sel;
  logic [7:0]  awAddr, arAddr;
  logic [31:0] wData, rData, memAddr, got;
  logic [1:0]  bResp, rResp, resp;
  ssw_events_t events;
  int          errCount = 0, nChecks = 0, cyc = 0;
  // Status bit raised by each agent event bit, event bit 0 first.
  int          stb[8] = '{31, 29, 28, 27, 30, 30, 24, 24};
  localparam logic [31:0] ST_FIXED = 32'h02200000;

  ssw_agents u_ssw_agents (.clk(clk), .rstn(rstn), .go(go), .sel(sel), .events(events));
  ssw_bank u_ssw_bank (.clk(clk), .rstn(rstn), .events(events), .memAddr(memAddr),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .commandParityResponse(cmdPar), .memForward(fwd), .irq(irq));

  // Clock and the hang limit; the limit is far above the expected run.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errCount++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nChecks++;
    if (g !== e) begin
      errCount++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Each channel drops its valid only at the edge where it was taken.
  task automatic axWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid);
    resp = bResp;
    bReady <= 1'b0;
  endtask : axWr

  task automatic axRd(input logic [7:0] a);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
    end while (!rValid);
    got = rData;
    resp = rResp;
    rReady <= 1'b0;
  endtask : axRd

  // Pulse one agent event, then let flag and interrupt settle.
  task automatic fire(input logic [2:0] k);
    @(posedge clk);
    sel <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : fire

  task automatic tReset();
    axRd(SSW_OFF_STATUS);
    chk(got, ST_FIXED);
    axRd(SSW_OFF_MEMWIN);
    chk(got, 32'h00000000);
    axRd(SSW_OFF_PREFBASE);
    chk(got, 32'h00000001);
    $display("test reset done");
  endtask : tReset

  task automatic tWindows();
    axWr(SSW_OFF_MEMWIN, 32'hFFFFFFFF);
    axRd(SSW_OFF_MEMWIN);
    chk(got, 32'hFFF0FFF0);
    axWr(SSW_OFF_PREFBASE, 32'hFFFFFFFF);
    axRd(SSW_OFF_PREFBASE);
    chk(got, 32'h0000FFF1);
    axWr(SSW_OFF_STATUS, 32'hFFFFFFFF);
    axRd(SSW_OFF_STATUS);
    chk(got, ST_FIXED);
    $display("test windows done");
  endtask : tWindows

  // Parity lines count only once the response enable is on.
  task automatic tEvents();
    fire(3'h7);
    axRd(SSW_OFF_STATUS);
    chk(got, ST_FIXED);
    axWr(SSW_OFF_CTRL, 32'h00000040);
    chk({31'h0, cmdPar}, 32'h1);
    for (int k = 0; k < 8; k++) begin
      fire(k[2:0]);
      axRd(SSW_OFF_STATUS);
      chk(got, ST_FIXED | (32'h1 << stb[k]));
    end
    $display("test events done");
  endtask : tEvents

  task automatic tClear();
    fire(3'h2);
    axWr(SSW_OFF_STATUS, 32'h00000000);
    axRd(SSW_OFF_STATUS);
    chk(got, ST_FIXED | 32'h10000000);
    fire(3'h2);
    axWr(SSW_OFF_STATUS, 32'h10000000);
    axRd(SSW_OFF_STATUS);
    chk(got, ST_FIXED);
    $display("test clear done");
  endtask : tClear

  task automatic tIrq();
    axWr(SSW_OFF_IRQMASK, 32'h00000010);
    fire(3'h2);
    chk({31'h0, irq}, 32'h1);
    axRd(SSW_OFF_STATUS);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    fire(3'h1);
    chk({31'h0, irq}, 32'h0);
    axRd(SSW_OFF_STATUS);
    $display("test irq done");
  endtask : tIrq

  // Window 1000_0000 to 1FFF_FFFF, probed just outside and on each edge.
  task automatic tForward();
    logic [31:0] adr[4] = '{32'h0FFFFFFF, 32'h10000000, 32'h1FFFFFFF, 32'h20000000};
    axWr(SSW_OFF_MEMWIN, 32'h1FF01000);
    for (int i = 0; i < 4; i++) begin
      memAddr <= adr[i];
      repeat (2) @(posedge clk);
      chk({31'h0, fwd}, {31'h0, (i == 1 || i == 2)});
    end
    axWr(8'h30, 32'h12345678);
    chk({30'h0, resp}, 32'h2);
    axRd(8'h30);
    chk(got | {30'h0, resp}, 32'h2);
    $display("test forward done");
  endtask : tForward

  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    {rstn, go, awValid, wValid, bReady, arValid, rReady} = '0;
    {sel, awAddr, arAddr, wData, memAddr} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    tReset();
    tWindows();
    tEvents();
    tClear();
    tIrq();
    tForward();
    summarize();
  end
endmodule : ssw_bank_bench
